// ---- hw/cpu_regfile.sv ----
/* Dedicated CPU register set with condition-code logic, interrupt admission,
   register bank address conversion and address space decode, reached over a
   classic Wishbone slave and a datapath write port.
   Assumes one clock, a synchronous reset and a master that holds each
   request until it sees ack. */
`include "cpu_regfile_consts.svh"

module cpu_regfile
   import cpu_regfile_pkg::*;
#(
   parameter int          BANKS    = 32,             // 16 for small RAM, 32 for large.
   parameter logic [15:0] ROM_BASE = `ROM_BASE_DEF   // Lowest program memory address.
) (
   input  wire logic        mclk,        // Core clock.
   input  wire logic        sys_rst,     // Synchronous reset, active high.
   input  wire logic        wb_cyc_i,    // Wishbone cycle.
   input  wire logic        wb_stb_i,    // Wishbone strobe.
   input  wire logic        wb_we_i,     // Wishbone write.
   input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address.
   input  wire logic [3:0]  wb_sel_i,    // Wishbone byte lanes.
   input  wire logic [31:0] wb_dat_i,    // Wishbone write data.
   output logic [31:0]      wb_dat_o,    // Wishbone read data.
   output logic             wb_ack_o,    // Wishbone acknowledge.
   input  wire core_wr_t    coreWr,      // Datapath register write.
   input  wire logic        irqReq,      // Pending interrupt request.
   input  wire logic [1:0]  irqLevel,    // Level of the pending request.
   output logic             irqAdmit,    // Request may be taken now.
   input  wire logic [2:0]  gprIndex,    // Register within the active bank.
   output logic [15:0]      gprAddr,     // RAM address of that register.
   input  wire logic [15:0] memAddr,     // Address to classify.
   output region_t          memRegion,   // Region of memAddr.
   output logic [15:0]      fetchAddr,   // Instruction pointer to the fetch unit.
   output logic [15:0]      accOut,      // Accumulator contents.
   output logic [15:0]      sopndOut,    // Second operand contents.
   output logic [15:0]      idxOut,      // Index modifier contents.
   output logic [15:0]      auxOut,      // Auxiliary pointer contents.
   output logic [15:0]      stkOut,      // Stack top pointer contents.
   output logic [15:0]      statOut      // Status word contents.
);

   localparam int          BANK_BITS = $clog2(BANKS);                // Bank number width.
   localparam logic [15:0] RAM_TOP   = 16'(`RAM_ORIGIN + BANKS * 8 * 2 - 1); // Last RAM byte.

   // Dedicated registers.
   logic [15:0] iptr_reg;      // Instruction pointer.
   logic [15:0] acc_reg;       // Accumulator.
   logic [15:0] sopnd_reg;     // Second operand.
   logic [15:0] idxm_reg;      // Index modifier.
   logic [15:0] auxp_reg;      // Auxiliary pointer.
   logic [15:0] stkp_reg;      // Stack top pointer.
   logic [7:0]  bank_reg;      // Bank select pointer, high half of the status word.
   logic [7:0]  flags_reg;     // Condition flag byte, low half of the status word.
   logic [1:0]  lastOp_reg;    // Last operation run, readable by software.
   logic        ack_reg;       // Registered acknowledge.
   logic [31:0] rdat_reg;      // Registered read data.

   // Bus decode.
   // A write lands on the edge at which ack is high, so it lands only once.
   wire         req       = wb_cyc_i & wb_stb_i;                 // Request present.
   wire         busWr     = req & wb_we_i & ack_reg;             // Write takes effect now.
   wire [15:0]  wdat      = wb_dat_i[15:0];                      // Write data low half.
   wire [15:0]  laneMask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}; // Byte lane mask.
   wire         hitIptr   = busWr & (wb_adr_i == `OFS_IPTR);
   wire         hitAcc    = busWr & (wb_adr_i == `OFS_ACC);
   wire         hitSopnd  = busWr & (wb_adr_i == `OFS_SOPND);
   wire         hitIdxm   = busWr & (wb_adr_i == `OFS_IDXM);
   wire         hitAuxp   = busWr & (wb_adr_i == `OFS_AUXP);
   wire         hitStkp   = busWr & (wb_adr_i == `OFS_STKP);
   wire         hitStat   = busWr & (wb_adr_i == `OFS_STAT);
   wire         hitOp     = busWr & (wb_adr_i == `OFS_ALUOP) & wb_sel_i[0];

   // Datapath write decode.
   wire         cIptr     = coreWr.we & (coreWr.id == REG_IPTR);
   wire         cAcc      = coreWr.we & (coreWr.id == REG_ACC);
   wire         cSopnd    = coreWr.we & (coreWr.id == REG_SOPND);
   wire         cIdxm     = coreWr.we & (coreWr.id == REG_IDXM);
   wire         cAuxp     = coreWr.we & (coreWr.id == REG_AUXP);
   wire         cStkp     = coreWr.we & (coreWr.id == REG_STKP);
   wire         cStat     = coreWr.we & (coreWr.id == REG_STAT);

   // Byte arithmetic on the low bytes of accumulator and second operand.
   alu_op_t     opCode;
   assign opCode = alu_op_t'(wb_dat_i[1:0]);
   wire [7:0]   aByte     = acc_reg[7:0];
   wire [7:0]   tByte     = sopnd_reg[7:0];
   wire [8:0]   sumFull   = {1'b0, aByte} + {1'b0, tByte};
   wire [8:0]   difFull   = {1'b0, aByte} - {1'b0, tByte};
   wire [4:0]   sumNib    = {1'b0, aByte[3:0]} + {1'b0, tByte[3:0]};
   wire [4:0]   difNib    = {1'b0, aByte[3:0]} - {1'b0, tByte[3:0]};
   wire         isSub     = (opCode == OP_SUB);
   wire         isShift   = (opCode == OP_SHL) | (opCode == OP_SHR);
   wire [7:0]   shlRes    = {aByte[6:0], 1'b0};
   wire [7:0]   shrRes    = {1'b0, aByte[7:1]};
   wire [7:0]   opRes     = (opCode == OP_ADD) ? sumFull[7:0] :
                            (opCode == OP_SUB) ? difFull[7:0] :
                            (opCode == OP_SHL) ? shlRes : shrRes;
   wire         carryOut  = (opCode == OP_ADD) ? sumFull[8] :
                            (opCode == OP_SUB) ? difFull[8] :
                            (opCode == OP_SHL) ? aByte[7] : aByte[0];
   wire         halfOut   = isSub ? difNib[4] : sumNib[4];
   wire         ovfAdd    = (aByte[7] == tByte[7]) & (opRes[7] != aByte[7]);
   wire         ovfSub    = (aByte[7] != tByte[7]) & (opRes[7] != aByte[7]);
   wire         ovfShift  = aByte[7] ^ opRes[7];
   wire         ovfOut    = isShift ? ovfShift : (isSub ? ovfSub : ovfAdd);
   wire         negOut    = opRes[7];
   wire         zeroOut   = (opRes == `ZERO_BYTE);

   // Flag byte after an operation; shifts leave half carry as it was.
   wire [7:0]   opFlags;
   assign opFlags[`FLG_H] = isShift ? flags_reg[`FLG_H] : halfOut;
   assign opFlags[`FLG_I] = flags_reg[`FLG_I];
   assign opFlags[`FLG_IL_HI:`FLG_IL_LO] = flags_reg[`FLG_IL_HI:`FLG_IL_LO];
   assign opFlags[`FLG_N] = negOut;
   assign opFlags[`FLG_Z] = zeroOut;
   assign opFlags[`FLG_V] = ovfOut;
   assign opFlags[`FLG_C] = carryOut;

   // Next values: datapath writes win over bus writes in the same cycle.
   wire [15:0]  iptr_next  = cIptr  ? coreWr.data :
                             hitIptr  ? (iptr_reg & ~laneMask) | (wdat & laneMask) : iptr_reg;
   wire [15:0]  acc_next   = cAcc   ? coreWr.data :
                             hitOp    ? {acc_reg[15:8], opRes} :
                             hitAcc   ? (acc_reg & ~laneMask) | (wdat & laneMask) : acc_reg;
   wire [15:0]  sopnd_next = cSopnd ? coreWr.data :
                             hitSopnd ? (sopnd_reg & ~laneMask) | (wdat & laneMask) : sopnd_reg;
   wire [15:0]  idxm_next  = cIdxm  ? coreWr.data :
                             hitIdxm  ? (idxm_reg & ~laneMask) | (wdat & laneMask) : idxm_reg;
   wire [15:0]  auxp_next  = cAuxp  ? coreWr.data :
                             hitAuxp  ? (auxp_reg & ~laneMask) | (wdat & laneMask) : auxp_reg;
   wire [15:0]  stkp_next  = cStkp  ? coreWr.data :
                             hitStkp  ? (stkp_reg & ~laneMask) | (wdat & laneMask) : stkp_reg;
   wire [7:0]   bank_next  = cStat  ? coreWr.data[15:8] :
                             (hitStat & wb_sel_i[1]) ? wdat[15:8] : bank_reg;
   wire [7:0]   flags_next = cStat  ? coreWr.data[7:0] :
                             hitOp  ? opFlags :
                             (hitStat & wb_sel_i[0]) ? wdat[7:0] : flags_reg;

   // Bank base address: origin plus bank number times eight. The bank number
   // wraps at the bank count, so a larger pointer aliases a lower bank.
   wire [BANK_BITS-1:0] bankNum = bank_reg[BANK_BITS-1:0];
   wire [15:0]  bankBase  = 16'(`RAM_ORIGIN + (16'(bankNum) << `BANK_SHIFT));
   assign gprAddr = bankBase | {13'h0, gprIndex};

   // Read multiplexer, sampled when the request is first seen.
   wire [15:0]  statWord  = {bank_reg, flags_reg};
   wire [31:0]  rdMux     = (wb_adr_i == `OFS_IPTR)  ? {16'h0000, iptr_reg}  :
                            (wb_adr_i == `OFS_ACC)   ? {16'h0000, acc_reg}   :
                            (wb_adr_i == `OFS_SOPND) ? {16'h0000, sopnd_reg} :
                            (wb_adr_i == `OFS_IDXM)  ? {16'h0000, idxm_reg}  :
                            (wb_adr_i == `OFS_AUXP)  ? {16'h0000, auxp_reg}  :
                            (wb_adr_i == `OFS_STKP)  ? {16'h0000, stkp_reg}  :
                            (wb_adr_i == `OFS_STAT)  ? {16'h0000, statWord}  :
                            (wb_adr_i == `OFS_ALUOP) ? {30'h0, lastOp_reg} :
                            (wb_adr_i == `OFS_IRQQ)  ? {31'h0, irqAdmit} :
                            (wb_adr_i == `OFS_BANKB) ? {16'h0000, bankBase} :
                            32'h00000000;

   // Interrupt admission: enabled, and the request level outranks the field.
   // Level 0 is the most urgent; a request at level 3 is never taken.
   wire [1:0]   ilField   = flags_reg[`FLG_IL_HI:`FLG_IL_LO];
   assign irqAdmit = irqReq & flags_reg[`FLG_I] & (irqLevel < ilField);

   // Address space decode: I/O lowest, RAM above it, program at the top.
   // Addresses between the top of RAM and the program base decode as none.
   assign memRegion = (memAddr <= `IO_TOP)   ? RGN_IO   :
                      (memAddr <= RAM_TOP)   ? RGN_RAM  :
                      (memAddr >= ROM_BASE)  ? RGN_PROG : RGN_NONE;

   assign wb_ack_o  = ack_reg;
   assign wb_dat_o  = rdat_reg;
   assign fetchAddr = iptr_reg;
   assign accOut    = acc_reg;
   assign sopndOut  = sopnd_reg;
   assign idxOut    = idxm_reg;
   assign auxOut    = auxp_reg;
   assign stkOut    = stkp_reg;
   assign statOut   = statWord;

   // Bus handshake: one wait state, ack drops the cycle after it was given.
   // Read data is captured every cycle but only means something under ack.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         ack_reg  <= req & ~ack_reg;
         rdat_reg <= rdMux;
      end
   end

   // Pointer and working register updates.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         iptr_reg  <= `RST_WORD;
         acc_reg   <= `RST_WORD;
         sopnd_reg <= `RST_WORD;
         idxm_reg  <= `RST_WORD;
         auxp_reg  <= `RST_WORD;
         stkp_reg  <= `RST_WORD;
      end else begin
         iptr_reg  <= iptr_next;
         acc_reg   <= acc_next;
         sopnd_reg <= sopnd_next;
         idxm_reg  <= idxm_next;
         auxp_reg  <= auxp_next;
         stkp_reg  <= stkp_next;
      end
   end

   // Status word; reset blocks interrupts and sets the lowest level.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bank_reg   <= `ZERO_BYTE;
         flags_reg  <= {2'h0, `RST_IL, 4'h0};
         lastOp_reg <= 2'h0;
      end else begin
         bank_reg   <= bank_next;
         flags_reg  <= flags_next;
         lastOp_reg <= hitOp ? wb_dat_i[1:0] : lastOp_reg;
      end
   end

   // Checks beside the logic.
   // An operation counts only when no datapath write to the accumulator
   // or the status word lands with it, since such writes win.
   sequence s_opIssued;
      hitOp & ~cStat & ~cAcc;
   endsequence
   sequence s_ackPulse;
      ack_reg ##1 ~ack_reg;
   endsequence

   // Bus handshake.
   property p_ack_drops;
      @(posedge mclk) disable iff (sys_rst) ack_reg |-> s_ackPulse;
   endproperty
   a_ack_drops: assert property (p_ack_drops) else $error("ack held two cycles");

   property p_ack_answers;
      @(posedge mclk) disable iff (sys_rst) (req & ~ack_reg) |=> ack_reg;
   endproperty
   a_ack_answers: assert property (p_ack_answers) else $error("no ack after request");

   // Interrupt enable and admission.
   property p_ien_reset;
      @(posedge mclk) sys_rst |=> ~flags_reg[`FLG_I];
   endproperty
   a_ien_reset: assert property (p_ien_reset) else $error("enable not cleared");

   property p_ien_gates;
      @(posedge mclk) disable iff (sys_rst)
         ~flags_reg[`FLG_I] |-> ~irqAdmit;
   endproperty
   a_ien_gates: assert property (p_ien_gates) else $error("admitted while off");

   property p_admit;
      @(posedge mclk) disable iff (sys_rst)
         irqAdmit |-> (flags_reg[`FLG_I] && irqLevel != 2'h3 && irqLevel < ilField);
   endproperty
   a_admit: assert property (p_admit) else $error("interrupt admitted wrongly");

   // Flags after a byte operation.
   property p_zero_flag;
      @(posedge mclk) disable iff (sys_rst)
         s_opIssued |=> (flags_reg[`FLG_Z] == (acc_reg[7:0] == `ZERO_BYTE));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

   property p_neg_flag;
      @(posedge mclk) disable iff (sys_rst)
         s_opIssued |=> (flags_reg[`FLG_N] == acc_reg[7]);
   endproperty
   a_neg_flag: assert property (p_neg_flag) else $error("negative flag mismatch");

   property p_add_carry;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_ADD)) |=>
            ({flags_reg[`FLG_C], acc_reg[7:0]} == $past(sumFull));
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry mismatch");

   property p_sub_carry;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_SUB)) |=>
            ({flags_reg[`FLG_C], acc_reg[7:0]} == $past(difFull));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("borrow mismatch");

   // A left shift puts the old sign bit into carry.
   property p_shl_carry;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_SHL)) |=>
            (flags_reg[`FLG_C] == $past(acc_reg[7]));
   endproperty
   a_shl_carry: assert property (p_shl_carry) else $error("shift carry mismatch");

   property p_ovf_add;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_ADD)) |=>
            (flags_reg[`FLG_V] == (($past(acc_reg[7]) == $past(sopnd_reg[7])) &&
                                   (acc_reg[7] != $past(acc_reg[7]))));
   endproperty
   a_ovf_add: assert property (p_ovf_add) else $error("overflow mismatch");

   property p_half_add;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_ADD)) |=> (flags_reg[`FLG_H] == $past(sumNib[4]));
   endproperty
   a_half_add: assert property (p_half_add) else $error("half carry mismatch");

   property p_half_sub;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and (opCode == OP_SUB)) |=>
            (flags_reg[`FLG_H] == ($past(acc_reg[3:0]) < $past(sopnd_reg[3:0])));
   endproperty
   a_half_sub: assert property (p_half_sub) else $error("half borrow mismatch");

   // Shifts leave the half carry alone.
   property p_half_shift;
      @(posedge mclk) disable iff (sys_rst)
         (s_opIssued and isShift) |=> (flags_reg[`FLG_H] == $past(flags_reg[`FLG_H]));
   endproperty
   a_half_shift: assert property (p_half_shift) else $error("shift moved half carry");

   property p_acc_high_kept;
      @(posedge mclk) disable iff (sys_rst)
         s_opIssued |=> (acc_reg[15:8] == $past(acc_reg[15:8]));
   endproperty
   a_acc_high_kept: assert property (p_acc_high_kept) else $error("high byte hit");

   // A datapath write lands whole at the next edge.
   property p_core_wins;
      @(posedge mclk) disable iff (sys_rst)
         cAcc |=> (acc_reg == $past(coreWr.data));
   endproperty
   a_core_wins: assert property (p_core_wins) else $error("datapath write lost");

   // Register and memory addressing.
   property p_bank_addr;
      @(posedge mclk) disable iff (sys_rst)
         gprAddr == 16'(`RAM_ORIGIN + 16'(bankNum) * 8 + 16'(gprIndex));
   endproperty
   a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

   property p_gpr_in_ram;
      @(posedge mclk) disable iff (sys_rst)
         (gprAddr >= `RAM_ORIGIN) && (gprAddr <= RAM_TOP);
   endproperty
   a_gpr_in_ram: assert property (p_gpr_in_ram) else $error("bank outside RAM");

   property p_io_region;
      @(posedge mclk) disable iff (sys_rst)
         (memAddr <= `IO_TOP) |-> (memRegion == RGN_IO);
   endproperty
   a_io_region: assert property (p_io_region) else $error("I/O decode wrong");

endmodule // cpu_regfile

// ---- hw/cpu_regfile_consts.svh ----
/* Constants of the dedicated register set: register offsets, flag positions,
   reset values and the memory map. Assumes inclusion by bare name. */
`ifndef CPU_REGFILE_CONSTS_SVH
`define CPU_REGFILE_CONSTS_SVH
`define OFS_IPTR      8'h00
`define OFS_ACC       8'h04
`define OFS_SOPND     8'h08
`define OFS_IDXM      8'h0C
`define OFS_AUXP      8'h10
`define OFS_STKP      8'h14
`define OFS_STAT      8'h18
`define OFS_ALUOP     8'h1C
`define OFS_IRQQ      8'h20
`define OFS_BANKB     8'h24
`define FLG_H         7
`define FLG_I         6
`define FLG_IL_HI     5
`define FLG_IL_LO     4
`define FLG_N         3
`define FLG_Z         2
`define FLG_V         1
`define FLG_C         0
`define RST_WORD      16'h0000
`define RST_IL        2'h3
`define RAM_ORIGIN    16'h0080
`define IO_TOP        16'h007F
`define ROM_BASE_DEF  16'hE000
`define BANK_SHIFT    3
`define ZERO_BYTE     8'h00
`endif

// ---- hw/cpu_regfile_pkg.sv ----
/* Types shared by the dedicated register set: register identifiers,
   arithmetic operation codes, memory regions and the core write carrier.
   Assumes nothing beyond a SystemVerilog compiler. */
package cpu_regfile_pkg;
   // Register chosen by a datapath write.
   typedef enum logic [2:0] {
      REG_IPTR  = 3'h0,
      REG_ACC   = 3'h1,
      REG_SOPND = 3'h2,
      REG_IDXM  = 3'h3,
      REG_AUXP  = 3'h4,
      REG_STKP  = 3'h5,
      REG_STAT  = 3'h6
   } reg_id_t;
   // Eight-bit operations run on the low bytes of accumulator and second operand.
   typedef enum logic [1:0] {
      OP_ADD = 2'h0,
      OP_SUB = 2'h1,
      OP_SHL = 2'h2,
      OP_SHR = 2'h3
   } alu_op_t;
   // Region of the unified address space that an address falls in.
   typedef enum logic [1:0] {
      RGN_IO   = 2'h0,
      RGN_RAM  = 2'h1,
      RGN_NONE = 2'h2,
      RGN_PROG = 2'h3
   } region_t;
   // One datapath write into a dedicated register.
   typedef struct packed {
      logic        we;
      reg_id_t     id;
      logic [15:0] data;
   } core_wr_t;
endpackage

// ---- verif/test_cpu_regfile.sv ----
/* Self-checking bench for the dedicated CPU register set: bus access, flags,
   interrupt admission, bank addressing and address decode.
   Assumes the design files are compiled first and the header is on the path. */
`include "cpu_regfile_consts.svh"

module test_cpu_regfile
   import cpu_regfile_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          BANKS    = 32;       // Large RAM variant.
   localparam logic [15:0] ROM_BASE = 16'hC000; // Program memory origin for this run.
   logic        mclk     = 1'b0;   // Core clock.
   logic        sys_rst  = 1'b1;   // Synchronous reset.
   logic        wb_cyc_i = 1'b0;   // Bus cycle.
   logic        wb_stb_i = 1'b0;   // Bus strobe.
   logic        wb_we_i  = 1'b0;   // Bus write.
   logic [7:0]  wb_adr_i = 8'h00;  // Bus address.
   logic [3:0]  wb_sel_i = 4'h0;   // Bus lanes.
   logic [31:0] wb_dat_i = 32'h0;  // Bus write data.
   logic [31:0] wb_dat_o;          // Bus read data.
   logic        wb_ack_o;          // Bus acknowledge.
   core_wr_t    coreWr   = '0;     // Datapath write.
   logic        irqReq   = 1'b0;   // Interrupt request.
   logic [1:0]  irqLevel = 2'h0;   // Request level.
   logic        irqAdmit;          // Admission result.
   logic [2:0]  gprIndex = 3'h0;   // Register within bank.
   logic [15:0] gprAddr;           // Register RAM address.
   logic [15:0] memAddr  = 16'h0;  // Address to classify.
   region_t     memRegion;         // Its region.
   logic [15:0] fetchAddr, accOut, sopndOut, idxOut, auxOut, stkOut, statOut;
   logic [95:0] allOut;            // Six plain registers side by side.
   logic [32:0] expQ[$];           // Expected bus answers: bit 32 asks for a compare.
   logic [32:0] note;              // Oldest note taken by the monitor.
   int          err_count = 0;     // Mismatches seen.
   int          checked   = 0;     // Comparisons made.
   int          seed      = 86820; // Random seed.
   assign allOut = {stkOut, auxOut, idxOut, sopndOut, accOut, fetchAddr};

   cpu_regfile #(.BANKS(BANKS), .ROM_BASE(ROM_BASE)) i_cpu_regfile (
      .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coreWr(coreWr), .irqReq(irqReq),
      .irqLevel(irqLevel), .irqAdmit(irqAdmit), .gprIndex(gprIndex), .gprAddr(gprAddr),
      .memAddr(memAddr), .memRegion(memRegion), .fetchAddr(fetchAddr), .accOut(accOut),
      .sopndOut(sopndOut), .idxOut(idxOut), .auxOut(auxOut), .stkOut(stkOut),
      .statOut(statOut));

   // Free-running clock, 4 ns period.
   initial begin
      forever #2 mclk = ~mclk;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Reports one mismatch.
   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
   endtask

   // Compares bus read data.
   task automatic cmpBus(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) fail(got, exp);
   endtask

   // Compares a sixteen-bit port value.
   task automatic cmpPort(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) fail({16'h0, got}, {16'h0, exp});
   endtask

   // Compares an address region code.
   task automatic cmpRgn(input region_t got, input region_t exp);
      checked++;
      if (got !== exp) fail({30'h0, got}, {30'h0, exp});
   endtask

   // One classic bus cycle; the note goes to the queue, the wait is bounded.
   task automatic wbAccess(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, input logic chk, input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      expQ.push_back({chk, exp});
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail(32'h0, 32'h1);
         tally_and_finish();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   // Full-word write and checked read, settled one step after the ack edge.
   task automatic wbWr(input logic [7:0] a, input logic [31:0] d);
      wbAccess(1'b1, a, d, 4'hF, 1'b0, 32'h0);
      #1;
   endtask
   task automatic wbRd(input logic [7:0] a, input logic [31:0] exp);
      wbAccess(1'b0, a, 32'h0, 4'hF, 1'b1, exp);
      #1;
   endtask

   // Datapath write: presented at one edge, taken at the next.
   task automatic coreSet(input reg_id_t id, input logic [15:0] d);
      @(posedge mclk);
      coreWr <= '{1'b1, id, d};
      @(posedge mclk);
      coreWr.we <= 1'b0;
   endtask

   // Reference byte operation: returns result byte and new flag byte.
   function automatic logic [15:0] aluRef(input alu_op_t op, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] fl);
      logic [8:0] r;
      logic       h;
      logic       v;
      h = fl[7];
      case (op)
         OP_ADD: begin
            r = {1'b0, a} + {1'b0, b};
            h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
            v = (a[7] == b[7]) && (r[7] != a[7]);
         end
         OP_SUB: begin
            r = {1'b0, a} - {1'b0, b};
            h = a[3:0] < b[3:0];
            v = (a[7] != b[7]) && (r[7] != a[7]);
         end
         OP_SHL: begin
            r = {a, 1'b0};
            v = r[7] ^ a[7];
         end
         default: begin
            r = {a[0], 1'b0, a[7:1]};
            v = r[7] ^ a[7];
         end
      endcase
      return {r[7:0], h, fl[6:4], r[7], r[7:0] == 8'h00, v, r[8]};
   endfunction

   // Monitor: every ack takes the oldest note and checks the read data when that note asks for a compare.
   always @(posedge mclk) begin
      if (wb_ack_o === 1'b1) begin
         if (expQ.size() == 0) fail(wb_dat_o, 32'h0);
         else begin
            note = expQ.pop_front();
            if (note[32]) cmpBus(wb_dat_o, note[31:0]);
         end
      end
   end

   // Main sequence.
   initial begin
      logic [31:0] d;
      logic [15:0] st;
      logic [15:0] r;
      logic [15:0] ix;
      logic [7:0]  a, b, bk;
      logic        e;
      logic [7:0]  ta[4] = '{8'hFF, 8'h80, 8'h80, 8'h01};
      logic [7:0]  tb[4] = '{8'h01, 8'h01, 8'h00, 8'h00};
      logic [15:0] rA[8] = '{16'h0000, 16'h007F, 16'h0080, 16'h027F, 16'h0280,
                             16'hBFFF, 16'hC000, 16'hFFFF};
      region_t     rR[8] = '{RGN_IO, RGN_IO, RGN_RAM, RGN_RAM, RGN_NONE, RGN_NONE,
                             RGN_PROG, RGN_PROG};
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      cmpPort(statOut, 16'h0030);
      // Plain registers: random write, read back over the bus and at the ports.
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         wbWr(8'(4 * i), d);
         if (i == 3) ix = d[15:0];
         wbRd(8'(4 * i), {16'h0, d[15:0]});
         cmpPort(allOut[16 * i +: 16], d[15:0]);
      end
      // Low lane only, then an unmapped place.
      wbAccess(1'b1, `OFS_IDXM, 32'h0000ABCD, 4'h1, 1'b0, 32'h0);
      #1;
      cmpPort(idxOut, {ix[15:8], 8'hCD});
      wbWr(8'h28, $random(seed));
      wbRd(8'h28, 32'h0);
      // Datapath writes reach every plain register.
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         coreSet(reg_id_t'(3'(i)), d[15:0]);
         #1;
         cmpPort(allOut[16 * i +: 16], d[15:0]);
      end
      // Byte operations: directed corner cases first, random ones after.
      st = 16'h0530;
      wbWr(`OFS_STAT, {16'h0, st});
      for (int i = 0; i < 20; i++) begin
         a = (i < 4) ? ta[i] : 8'($random(seed));
         b = (i < 4) ? tb[i] : 8'($random(seed));
         bk = 8'($random(seed));
         wbWr(`OFS_ACC, {16'h0, bk, a});
         wbWr(`OFS_SOPND, {24'h0, b});
         wbWr(`OFS_ALUOP, {30'h0, 2'(i)});
         r = aluRef(alu_op_t'(2'(i)), a, b, st[7:0]);
         st = {st[15:8], r[7:0]};
         cmpPort(accOut, {bk, r[15:8]});
         cmpPort(statOut, st);
         wbRd(`OFS_ALUOP, {30'h0, 2'(i)});
      end
      // Bank pointer to register address, bank number wraps at the bank count.
      for (int k = 0; k < 3; k++) begin
         bk = (k == 0) ? 8'h00 : (k == 1) ? 8'h25 : 8'h1F;
         coreSet(REG_STAT, {bk, 8'h30});
         for (int j = 0; j < 8; j++) begin
            @(posedge mclk);
            gprIndex <= 3'(j);
            #1;
            cmpPort(gprAddr, 16'h0080 + 16'(bk % BANKS) * 16'h0008 + 16'(j));
         end
         cmpPort(statOut, {bk, 8'h30});
         wbRd(`OFS_BANKB, 32'h0080 + 32'(bk % BANKS) * 32'h8);
      end
      // Every combination of request, enable, level field and request level.
      for (int k = 0; k < 64; k++) begin
         coreSet(REG_STAT, {8'h00, 1'b0, k[4], k[3:2], 4'h0});
         irqReq   <= k[5];
         irqLevel <= k[1:0];
         #1;
         e = k[5] & k[4] & (k[1:0] < k[3:2]);
         cmpPort({15'h0, irqAdmit}, {15'h0, e});
         wbRd(`OFS_IRQQ, {31'h0, e});
      end
      // Address space boundaries.
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         memAddr <= rA[k];
         #1;
         cmpRgn(memRegion, rR[k]);
      end
      // Reset in mid-run clears the interrupt enable, the bank pointer and the accumulator.
      coreSet(REG_STAT, 16'h1F70);
      @(posedge mclk);
      sys_rst <= 1'b1;
      @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      cmpPort(statOut, 16'h0030);
      cmpPort(accOut, 16'h0000);
      wbRd(`OFS_STAT, 32'h0030);
      tally_and_finish();
   end
endmodule // test_cpu_regfile
